// ---- design/dscp_top.sv ----
// Control logic of a serial voltage-output converter: port, update, preset, fault
// Functional notes
// - Reset clamps output, powers buffer down
// - Frame select low bounds each transfer
// - Word acted on at frame select rise
// - Bits shifted in on shift clock falls
// - Daisy or readback drives shift register out
// - Output changes rising, host samples falling
// - Load strobe low updates converter immediately
// - Load strobe high defers until its fall
// - Preset fall loads zero, mid or full
// - Fault flag low on heat, short, brownout
// - Flag held low after reset until control write
`include "dscp_regs.svh"

module dscp_top (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         resetn,
  // Serial link
  input  wire logic         sclk,
  input  wire logic         frame_n,
  input  wire logic         serial_in,
  output logic              serial_out,
  // Update and preset strobes
  input  wire logic         load_strobe_n,
  input  wire logic         preset_n,
  // Fault detectors
  input  wire logic         temp_hot,
  input  wire logic         out_short,
  input  wire logic         brownout,
  // Converter side
  output dscp_pkg::dscp_code_t dac_code,
  output logic              out_clamp,
  output logic              buf_pd,
  output logic              fault_n,
  output logic              dac_update
);
  import dscp_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [6:0]   sync_s;
  logic         rst_n_s;
  logic         frame_s;
  logic         load_s;
  logic         preset_s;
  logic         hot_s;
  logic         short_s;
  logic         brown_s;

  logic         frame_q;
  logic         load_q;
  logic         preset_q;

  dscp_word_t   word;
  logic         word_ok;

  dscp_code_t   in_r;
  dscp_code_t   in_nxt;
  dscp_code_t   dac_r;
  dscp_code_t   dac_nxt;
  dscp_ctrl_t   ctrl_r;
  logic         clamp_r;
  logic         pd_r;
  logic         hold_r;
  logic         hold_nxt;
  logic         fault_n_r;
  logic         upd_r;
  dscp_word_t   rb_word_r;
  logic         rb_pend_r;

  logic         frame_end;
  logic         wr_ok;
  logic [`DSCP_CMD_W-1:0] cmd;
  dscp_code_t   data;
  logic         is_wr_in;
  logic         is_upd;
  logic         is_wr_ctrl;
  logic         is_rb;
  logic         is_swrst;
  logic         load_fall;
  logic         preset_fall;
  logic         dac_load;
  logic         fault_any;
  logic         tx_en;
  dscp_code_t   rb_data;
  dscp_preset_t ps_sel;

  // Code loaded by a preset edge
  function automatic dscp_code_t preset_code(input dscp_preset_t sel);
    case (sel)
      DSCP_PS_MID:  preset_code = `DSCP_CODE_MID;
      DSCP_PS_FULL: preset_code = `DSCP_CODE_FULL;
      default:      preset_code = `DSCP_CODE_ZERO;
    endcase
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Every pin level used on clock passes two flops before use
  dscp_sync #(
    .W (7)
  ) u_sync (
    .clock (clock),
    .d     ({resetn, frame_n, load_strobe_n, preset_n,
             temp_hot, out_short, brownout}),
    .q     (sync_s)
  );

  assign {rst_n_s, frame_s, load_s, preset_s,
          hot_s, short_s, brown_s} = sync_s;

  // ****************************************************************
  // Shift-clock domain
  // ****************************************************************
  // Word and count are stable whenever frame_n is high
  dscp_link #(
    .W (`DSCP_FRAME_W)
  ) u_link (
    .sclk       (sclk),
    .frame_n    (frame_n),
    .serial_in  (serial_in),
    .serial_out (serial_out),
    .tx_en      (tx_en),
    .rb_pend    (rb_pend_r),
    .rb_word    (rb_word_r),
    .word       (word),
    .word_ok    (word_ok)
  );

  // ****************************************************************
  // Edge detection and command decode
  // ****************************************************************
  // Previous synchronised levels for edge detection
  always_ff @(posedge clock) begin
    if (!rst_n_s) begin
      frame_q  <= 1'b1;
      load_q   <= 1'b1;
      preset_q <= 1'b1;
    end else begin
      frame_q  <= frame_s;
      load_q   <= load_s;
      preset_q <= preset_s;
    end
  end

  // Edges and frame decode
  assign frame_end   = frame_s & ~frame_q;
  assign load_fall   = ~load_s & load_q;
  assign preset_fall = ~preset_s & preset_q;
  assign wr_ok       = frame_end & word_ok;
  assign cmd         = word[`DSCP_CMD_HI:`DSCP_CMD_LO];
  assign data        = word[`DSCP_CODE_W-1:0];
  assign is_wr_in    = wr_ok && (cmd == `DSCP_CMD_WR_IN || cmd == `DSCP_CMD_WR_UPD);
  assign is_upd      = wr_ok && (cmd == `DSCP_CMD_UPDATE);
  assign is_wr_ctrl  = wr_ok && (cmd == `DSCP_CMD_WR_CTRL);
  assign is_swrst    = wr_ok && (cmd == `DSCP_CMD_SW_RST);
  assign is_rb       = wr_ok && (cmd == `DSCP_CMD_RB_IN || cmd == `DSCP_CMD_RB_DAC ||
                                 cmd == `DSCP_CMD_RB_CTRL);
  assign ps_sel      = dscp_preset_t'(ctrl_r[`DSCP_CTRL_PS_HI:`DSCP_CTRL_PS_LO]);

  // ****************************************************************
  // Input and converter registers
  // ****************************************************************
  // Preset first, then the written word, else the held input
  assign in_nxt   = is_wr_in ? data : in_r;
  assign dac_load = preset_fall | load_fall | is_upd |
                    (is_wr_in & (~load_s | (cmd == `DSCP_CMD_WR_UPD)));
  assign dac_nxt  = preset_fall ? preset_code(ps_sel) : in_nxt;

  // Input register and converter register
  always_ff @(posedge clock) begin
    if (!rst_n_s || is_swrst) begin
      in_r  <= `DSCP_CODE_RST;
      dac_r <= `DSCP_CODE_RST;
      upd_r <= 1'b0;
    end else begin
      in_r  <= in_nxt;
      dac_r <= dac_load ? dac_nxt : dac_r;
      upd_r <= dac_load;
    end
  end

  // ****************************************************************
  // Control, output stage and fault flag
  // ****************************************************************
  // Control register steers preset, chain and output stage
  always_ff @(posedge clock) begin
    if (!rst_n_s || is_swrst) begin
      ctrl_r  <= `DSCP_CTRL_RST;
      clamp_r <= 1'b1;
      pd_r    <= 1'b1;
    end else if (is_wr_ctrl) begin
      ctrl_r  <= data[`DSCP_CTRL_W-1:0];
      clamp_r <= ~data[`DSCP_CTRL_OUTEN];
      pd_r    <= ~data[`DSCP_CTRL_OUTEN];
    end
  end

  // Hold set by any reset, released only by a control write
  assign fault_any = hot_s | short_s | brown_s;
  assign hold_nxt  = is_wr_ctrl ? 1'b0 : hold_r;

  // Fault flag register
  always_ff @(posedge clock) begin
    if (!rst_n_s || is_swrst) begin
      hold_r    <= 1'b1;
      fault_n_r <= 1'b0;
    end else begin
      hold_r    <= hold_nxt;
      fault_n_r <= ~(hold_nxt | fault_any);
    end
  end

  // ****************************************************************
  // Readback and daisy chain
  // ****************************************************************
  // Readback data picked by the command
  assign rb_data = (cmd == `DSCP_CMD_RB_DAC)  ? dac_r :
                   (cmd == `DSCP_CMD_RB_CTRL) ? dscp_code_t'(ctrl_r) : in_r;
  assign tx_en   = ctrl_r[`DSCP_CTRL_DAISY] | rb_pend_r;

  // Readback word lasts exactly one following frame
  always_ff @(posedge clock) begin
    if (!rst_n_s) begin
      rb_pend_r <= 1'b0;
      rb_word_r <= '0;
    end else if (frame_end) begin
      rb_pend_r <= is_rb;
      rb_word_r <= is_rb ? {cmd, 4'h0, rb_data} : rb_word_r;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Every output is a flop
  assign dac_code   = dac_r;
  assign out_clamp  = clamp_r;
  assign buf_pd     = pd_r;
  assign fault_n    = fault_n_r;
  assign dac_update = upd_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n_s);

  // Write taken while the load strobe is low
  sequence s_wr_low;
    is_wr_in && !load_s && !preset_fall;
  endsequence

  // Write taken while the load strobe is high
  sequence s_wr_high;
    is_wr_in && load_s && cmd == `DSCP_CMD_WR_IN && !preset_fall;
  endsequence

  a_reset_clamp: assert property (disable iff (1'b0)
    !rst_n_s |=> out_clamp && buf_pd && dac_code == `DSCP_CODE_RST && !fault_n)
    else $error("reset did not clamp output");

  a_frame_latch: assert property (
    (in_r != $past(in_r)) |-> $past(frame_end))
    else $error("input register changed outside frame end");

  a_load_strobe_n_immed: assert property (
    s_wr_low |=> dac_code == $past(data) && dac_update)
    else $error("write with load low did not update");

  a_load_strobe_n_defer: assert property (
    s_wr_high ##1 !load_fall && !preset_fall && !is_upd && !is_swrst
    |-> $stable(dac_code))
    else $error("write with load high changed converter");

  a_load_strobe_n_fall: assert property (
    load_fall && !preset_fall && !is_wr_in && !is_swrst |=> dac_code == $past(in_r))
    else $error("load fall did not transfer input register");

  a_preset_code: assert property (
    preset_fall && !is_swrst |=> dac_code == preset_code($past(ps_sel)))
    else $error("preset fall loaded wrong code");

  a_fault_low: assert property (
    fault_any |=> !fault_n)
    else $error("fault condition did not pull flag low");

  a_fault_hold: assert property (
    $rose(fault_n) |-> $past(is_wr_ctrl) || $past(hold_r) == 1'b0)
    else $error("fault flag released without control write");

  a_sync_delay: assert property (
    load_fall |-> !$past(load_strobe_n, 2) && $past(load_strobe_n, 3))
    else $error("load edge seen without two-stage delay");
endmodule

// ---- design/dscp_regs.svh ----
// Constants of the serial converter control block: frame layout, codes, resets
`ifndef DSCP_REGS_SVH
`define DSCP_REGS_SVH

// ****************************************************************
// Frame layout
// ****************************************************************
`define DSCP_FRAME_W      24
`define DSCP_CODE_W       16
`define DSCP_CMD_HI       23
`define DSCP_CMD_LO       20
`define DSCP_CMD_W        4

// ****************************************************************
// Command codes
// ****************************************************************
`define DSCP_CMD_WR_IN    4'h1
`define DSCP_CMD_UPDATE   4'h2
`define DSCP_CMD_WR_UPD   4'h3
`define DSCP_CMD_WR_CTRL  4'h4
`define DSCP_CMD_RB_IN    4'ha
`define DSCP_CMD_RB_DAC   4'hb
`define DSCP_CMD_RB_CTRL  4'hc
`define DSCP_CMD_SW_RST   4'hf

// ****************************************************************
// Control register fields and reset values
// ****************************************************************
`define DSCP_CTRL_W       4
`define DSCP_CTRL_PS_HI   1
`define DSCP_CTRL_PS_LO   0
`define DSCP_CTRL_DAISY   2
`define DSCP_CTRL_OUTEN   3
`define DSCP_CTRL_RST     4'h0
`define DSCP_CODE_RST     16'h0000

// ****************************************************************
// Preset codes
// ****************************************************************
`define DSCP_CODE_ZERO    16'h0000
`define DSCP_CODE_MID     16'h8000
`define DSCP_CODE_FULL    16'hffff

`endif

// ---- design/dscp_pkg.sv ----
// Types shared by the serial converter control block
package dscp_pkg;
  `include "dscp_regs.svh"

  typedef logic [`DSCP_CODE_W-1:0]  dscp_code_t;
  typedef logic [`DSCP_FRAME_W-1:0] dscp_word_t;
  typedef logic [`DSCP_CTRL_W-1:0]  dscp_ctrl_t;

  // Preset selection held in the control register
  typedef enum logic [1:0] {
    DSCP_PS_ZERO,
    DSCP_PS_MID,
    DSCP_PS_FULL,
    DSCP_PS_SPARE
  } dscp_preset_t;
endpackage

// ---- design/dscp_sync.sv ----
// Two-stage synchroniser for a group of asynchronous levels
module dscp_sync #(
  parameter int W = 1
) (
  // Clock
  input  wire logic         clock,
  // Levels in and out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage is read only by the second
  always_ff @(posedge clock) begin
    meta_r <= d;
    q      <= meta_r;
  end
endmodule

// ---- design/dscp_link.sv ----
// Shift-clock side of the serial port: input shifter and serial output
module dscp_link #(
  parameter int W = 24
) (
  // Link pins
  input  wire logic         sclk,
  input  wire logic         frame_n,
  input  wire logic         serial_in,
  output logic              serial_out,
  // Quasi-static controls, stable while frame_n is low
  input  wire logic         tx_en,
  input  wire logic         rb_pend,
  input  wire logic [W-1:0] rb_word,
  // Received word, stable while frame_n is high
  output logic      [W-1:0] word,
  output logic              word_ok
);
  localparam int CW = $clog2(W + 1);

  logic          in_frame_r;
  logic [CW-1:0] cnt_r;
  logic [W-1:0]  sh_r;
  logic [W-1:0]  load_w;
  logic          tx_bit;

  // Frame start takes readback data, else keeps last word for the chain
  assign load_w  = (!in_frame_r && rb_pend) ? rb_word : sh_r;
  assign tx_bit  = in_frame_r ? sh_r[W-1] : load_w[W-1];
  assign word    = sh_r;
  assign word_ok = (cnt_r >= CW'(W));

  // Frame flag cleared by the frame's own end
  always_ff @(negedge sclk or posedge frame_n) begin
    if (frame_n) begin
      in_frame_r <= 1'b0;
    end else begin
      in_frame_r <= 1'b1;
    end
  end

  // Bits shifted in on falling edges
  always_ff @(negedge sclk) begin
    sh_r  <= {load_w[W-2:0], serial_in};
    cnt_r <= !in_frame_r ? CW'(1) : (word_ok ? cnt_r : cnt_r + CW'(1));
  end

  // Output bit changes on rising edges, low outside frames
  always_ff @(posedge sclk or posedge frame_n) begin
    if (frame_n) begin
      serial_out <= 1'b0;
    end else begin
      serial_out <= tx_en & tx_bit;
    end
  end

  a_shift_in: assert property (@(negedge sclk) disable iff (frame_n)
    in_frame_r |=> sh_r[0] == $past(serial_in))
    else $error("serial input bit not shifted in");
endmodule

// ---- verification/dscp_host_model.sv ----
// Host serial master model: framed transfers and readback capture
module dscp_host_model (
  // Link pins towards the device
  output logic      sclk,
  output logic      frame_n,
  output logic      serial_in,
  input  wire logic serial_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // Idle link
  // ****************************************************************
  // Shift clock stands low and frame select high outside frames
  initial begin
    sclk      = 1'b0;
    frame_n   = 1'b0;
    serial_in = 1'b0;
    // A real rising edge clears the link's frame state at start-up
    #1 frame_n = 1'b1;
  end

  // ****************************************************************
  // One frame
  // ****************************************************************
  // Sends the low n bits of w MSB first, collects serial_out into r
  task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] r);
    r = 24'h000000;
    #1.3;
    frame_n = 1'b0;
    #3;
    for (int i = n - 1; i >= 0; i--) begin
      // Data moves on the rising edge, well clear of the sampling fall
      #3 sclk = 1'b1;
      serial_in = w[i];
      #3 sclk = 1'b0;
      r = {r[22:0], serial_out};
    end
    #3 frame_n = 1'b1;
    // Released data line shows the inverse of its last value
    serial_in = ~serial_in;
    // Spacing between frames, well above 20 ns
    #24;
  endtask
endmodule

// ---- verification/dac_serial_control_pins_tb_top.sv ----
// Self-checking bench of the serial converter control block
`include "dscp_regs.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module dac_serial_control_pins_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import dscp_pkg::*;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic       clock = 1'b0;
  logic       resetn = 1'b0;
  logic       sclk;
  logic       frame_n;
  logic       serial_in;
  logic       serial_out;
  logic       load_strobe_n = 1'b1;
  logic       preset_n = 1'b1;
  logic       temp_hot = 1'b0;
  logic       out_short = 1'b0;
  logic       brownout = 1'b0;
  dscp_code_t dac_code;
  logic       out_clamp;
  logic       buf_pd;
  logic       fault_n;
  logic       dac_update;
  logic [23:0] rd;
  int         bad_count = 0;
  int         checks_done = 0;
  int         upd_cnt = 0;

  // System clock, 4 ns period
  always #2 clock = ~clock;

  // Counts converter load pulses
  always @(posedge clock) if (dac_update === 1'b1) upd_cnt <= upd_cnt + 1;

  // ****************************************************************
  // Design and host
  // ****************************************************************
  dscp_top DUT (
    .clock(clock), .resetn(resetn), .sclk(sclk), .frame_n(frame_n),
    .serial_in(serial_in), .serial_out(serial_out), .load_strobe_n(load_strobe_n),
    .preset_n(preset_n), .temp_hot(temp_hot), .out_short(out_short),
    .brownout(brownout), .dac_code(dac_code), .out_clamp(out_clamp),
    .buf_pd(buf_pd), .fault_n(fault_n), .dac_update(dac_update)
  );
  dscp_host_model host (
    .sclk(sclk), .frame_n(frame_n), .serial_in(serial_in), .serial_out(serial_out)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  // Full frame, then time for the effect to land
  task automatic frame(input logic [3:0] cmd, input logic [15:0] d);
    host.xfer({cmd, 4'h0, d}, 24, rd);
    cyc(6);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Hardware reset pulse; values during and after it
  task automatic t_hwrst;
    resetn = 1'b0;
    cyc(12);
    `CHK(dac_code, 16'h0000)
    `CHK(out_clamp, 1'b1)
    `CHK(buf_pd, 1'b1)
    resetn = 1'b1;
    cyc(5);
    `CHK(fault_n, 1'b0)
    $display("test hwrst done");
  endtask

  // Control write releases flag and output; control readback
  task automatic t_ctrl;
    frame(`DSCP_CMD_WR_CTRL, 16'h0008);
    `CHK(fault_n, 1'b1)
    `CHK(out_clamp, 1'b0)
    `CHK(buf_pd, 1'b0)
    frame(`DSCP_CMD_RB_CTRL, 16'h0000);
    frame(4'h0, 16'h0000);
    `CHK(rd, 24'hc00008)
    $display("test ctrl done");
  endtask

  // Strobe low and high, update commands, converter readback
  task automatic t_load;
    int n0;
    load_strobe_n = 1'b0;
    // Let the strobe's own fall land before counting
    cyc(6);
    n0 = upd_cnt;
    frame(`DSCP_CMD_WR_IN, 16'h1234);
    `CHK(dac_code, 16'h1234)
    `CHK(upd_cnt - n0, 1)
    load_strobe_n = 1'b1;
    cyc(3);
    frame(`DSCP_CMD_WR_IN, 16'habcd);
    `CHK(dac_code, 16'h1234)
    frame(`DSCP_CMD_RB_IN, 16'h0000);
    frame(4'h0, 16'h0000);
    `CHK(rd, 24'ha0abcd)
    load_strobe_n = 1'b0;
    cyc(6);
    `CHK(dac_code, 16'habcd)
    load_strobe_n = 1'b1;
    frame(`DSCP_CMD_WR_UPD, 16'h0f0f);
    `CHK(dac_code, 16'h0f0f)
    frame(`DSCP_CMD_WR_IN, 16'h5a5a);
    frame(`DSCP_CMD_UPDATE, 16'h0000);
    `CHK(dac_code, 16'h5a5a)
    frame(`DSCP_CMD_RB_DAC, 16'h0000);
    frame(4'h0, 16'h0000);
    `CHK(rd, 24'hb05a5a)
    $display("test load done");
  endtask

  // Short frame ignored; daisy echo of the previous word
  task automatic t_frames;
    load_strobe_n = 1'b0;
    // Would write 16'h7777 if a 23-bit frame were taken
    host.xfer(24'h117777, 23, rd);
    cyc(6);
    `CHK(dac_code, 16'h5a5a)
    frame(`DSCP_CMD_WR_CTRL, 16'h000c);
    frame(4'h0, 16'h1357);
    frame(4'h0, 16'h0000);
    `CHK(rd, 24'h001357)
    load_strobe_n = 1'b1;
    $display("test frames done");
  endtask

  // Every preset selection
  task automatic t_preset;
    dscp_code_t exp_code [4];
    exp_code = '{`DSCP_CODE_ZERO, `DSCP_CODE_MID, `DSCP_CODE_FULL, `DSCP_CODE_ZERO};
    for (int ps = 0; ps < 4; ps++) begin
      frame(`DSCP_CMD_WR_UPD, 16'h1234);
      frame(`DSCP_CMD_WR_CTRL, 16'h0008 | 16'(ps));
      preset_n = 1'b0;
      cyc(6);
      `CHK(dac_code, exp_code[ps])
      preset_n = 1'b1;
      cyc(3);
    end
    $display("test preset done");
  endtask

  // Each detector pulls the flag low, then lets it go
  task automatic t_fault;
    for (int k = 0; k < 3; k++) begin
      {temp_hot, out_short, brownout} = 3'b100 >> k;
      cyc(4);
      `CHK(fault_n, 1'b0)
      {temp_hot, out_short, brownout} = 3'b000;
      cyc(4);
      `CHK(fault_n, 1'b1)
    end
    $display("test fault done");
  endtask

  // Software reset returns the defaults
  task automatic t_swrst;
    frame(`DSCP_CMD_SW_RST, 16'h0000);
    `CHK(dac_code, 16'h0000)
    `CHK(out_clamp, 1'b1)
    `CHK(buf_pd, 1'b1)
    `CHK(fault_n, 1'b0)
    $display("test swrst done");
  endtask

  // ****************************************************************
  // Sequence and watchdog
  // ****************************************************************
  initial begin
    t_hwrst();
    t_ctrl();
    t_load();
    t_frames();
    t_preset();
    t_fault();
    t_swrst();
    t_ctrl();
    t_hwrst();
    finish_test();
  end

  // Tests need about 6 us; stop a hang well after that
  initial begin
    #60000;
    bad_count++;
    finish_test();
  end
endmodule
